/* fsr_semaphore_top.sv */
// software/firmware shared-resource semaphore with firmware command handling
// assumes register master and command source on core_clk; no pin inputs

module fsr_semaphore_top import fsr_pkg::*; #(
  parameter int          NRES         = NRES_DEF,
  parameter int          LOCK_TMO_CYC_P = LOCK_TMO_CYC,
  parameter int          RETRY_CYC_P  = RETRY_CYC,
  parameter int          FORCE_CYC_P  = FORCE_CYC,
  parameter int          TOKEN_CYC_P  = TOKEN_CYC,
  parameter logic [24:0] SR_LIMIT     = SR_LIMIT_DEF,
  parameter logic [24:0] SR_WR_LO     = SR_WR_LO_DEF,
  parameter logic [24:0] FLASH_WR_END = FLASH_WR_END_DEF
) (
  // clock and control
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic            clk_en,
  // register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [31:0]          reg_rdata,
  // firmware resource requests
  input  wire logic            fw_req,
  input  wire logic [NRES-1:0] fw_req_mask,
  input  wire logic            fw_rel,
  output logic                 fw_grant,
  output logic                 fw_busy,
  // firmware command port
  input  wire logic            cmd_valid,
  input  wire fsr_cmd_t        cmd,
  output logic                 cmd_ready,
  output logic                 resp_valid,
  output fsr_resp_t            resp,
  output logic                 fw_reset_pulse,
  // management path controls
  output logic                 host_to_mgmt_path,
  output logic                 receive_enable_bit
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (NRES < 1 || NRES > MAX_RES) begin : g_bad_nres
    $error("NRES out of range");
  end
  if (LOCK_TMO_CYC_P < 1 || RETRY_CYC_P < 1 || FORCE_CYC_P < 1 || TOKEN_CYC_P < 1 ||
      LOCK_TMO_CYC_P >= 2**TMR_W || RETRY_CYC_P >= 2**TMR_W ||
      FORCE_CYC_P >= 2**TMR_W || TOKEN_CYC_P >= 2**TMR_W) begin : g_bad_cyc
    $error("timer count out of range");
  end

  // ------------------------------------------------------------
  // decode and timers
  // ------------------------------------------------------------
  logic sem_rd;
  logic sem_wr;
  logic own_wr;
  logic tok_wr;
  logic mgmt_wr;
  assign sem_rd  = reg_rd && reg_addr == ADDR_SEM;
  assign sem_wr  = reg_wr && reg_addr == ADDR_SEM;
  assign own_wr  = reg_wr && reg_addr == ADDR_OWN;
  assign tok_wr  = reg_wr && reg_addr == ADDR_TOKEN;
  assign mgmt_wr = reg_wr && reg_addr == ADDR_MGMT;

  logic [NUM_TMR-1:0] tmr_start;
  logic [NUM_TMR-1:0] tmr_stop;
  logic [NUM_TMR-1:0] tmr_exp;
  logic [TMR_W-1:0]   tmr_load [NUM_TMR];
  logic lock_start;
  logic retry_start;
  logic force_start;
  logic force_stop;
  logic tok_start;
  logic tok_stop;
  assign tmr_start = {tok_start, force_start, retry_start, lock_start};
  assign tmr_stop  = {tok_stop, force_stop, 1'b0, 1'b0};
  assign tmr_load[T_LOCK]  = TMR_W'(LOCK_TMO_CYC_P);
  assign tmr_load[T_RETRY] = TMR_W'(RETRY_CYC_P);
  assign tmr_load[T_FORCE] = TMR_W'(FORCE_CYC_P);
  assign tmr_load[T_TOKEN] = TMR_W'(TOKEN_CYC_P);

  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    fsr_timer #(.W(TMR_W)) u_tmr (
      .core_clk (core_clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .start    (tmr_start[i]),
      .stop     (tmr_stop[i]),
      .load     (tmr_load[i]),
      .expired  (tmr_exp[i])
    );
  end

  // ------------------------------------------------------------
  // interlock and ownership registers, firmware semaphore engine
  // ------------------------------------------------------------
  fsr_sem_state_t  state_reg;
  fsr_sem_state_t  state_next;
  logic [NRES-1:0] req_reg;
  logic [NRES-1:0] req_next;
  logic [NRES-1:0] sw_bits_reg;
  logic [NRES-1:0] sw_next;
  logic [NRES-1:0] fw_bits_reg;
  logic [NRES-1:0] fw_next;
  logic            lock_reg;
  logic            lock_next;
  logic            il_reg;
  logic            il_next;

  always_comb begin
    state_next  = state_reg;
    req_next    = req_reg;
    sw_next     = sw_bits_reg;
    fw_next     = fw_bits_reg;
    lock_next   = lock_reg;
    il_next     = il_reg;
    lock_start  = 1'b0;
    retry_start = 1'b0;
    force_start = 1'b0;
    force_stop  = 1'b0;
    if (sem_rd && !il_reg) begin
      il_next = 1'b1;
    end
    if (sem_wr) begin
      il_next = reg_wdata[SEM_IL_POS];
    end
    unique case (state_reg)
      S_IDLE: begin
        if (fw_req && fw_req_mask != '0) begin
          req_next    = fw_req_mask;
          force_start = 1'b1;
          lock_start  = 1'b1;
          state_next  = S_POLL;
        end
      end
      S_POLL, S_RPOLL: begin
        // take free lock, or seize it on timeout
        if (!own_wr && (!lock_reg || tmr_exp[T_LOCK])) begin
          lock_next  = 1'b1;
          state_next = (state_reg == S_POLL) ? S_CHECK : S_RCLR;
        end
      end
      S_CHECK: begin
        if (!own_wr) begin
          lock_next = 1'b0;
          // claim where software bit clear, or force the claim when the force timer expires
          if ((sw_bits_reg & req_reg) == '0) begin
            fw_next    = fw_bits_reg | req_reg;
            force_stop = 1'b1;
            state_next = S_OWN;
          end else if (tmr_exp[T_FORCE]) begin
            sw_next    = sw_bits_reg & ~req_reg;
            fw_next    = fw_bits_reg | req_reg;
            force_stop = 1'b1;
            state_next = S_OWN;
          end else begin
            retry_start = 1'b1;
            state_next  = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (tmr_exp[T_RETRY]) begin
          lock_start = 1'b1;
          state_next = S_POLL;
        end
      end
      S_OWN: begin
        if (fw_rel) begin
          lock_start = 1'b1;
          state_next = S_RPOLL;
        end
      end
      S_RCLR: begin
        // clear own bits, unlock, back off
        if (!own_wr) begin
          fw_next     = fw_bits_reg & ~req_reg;
          lock_next   = 1'b0;
          retry_start = 1'b1;
          state_next  = S_BACK;
        end
      end
      S_BACK: begin
        if (tmr_exp[T_RETRY]) begin
          state_next = S_IDLE;
        end
      end
    endcase
    // a software claim drops the firmware bit
    if (own_wr) begin
      sw_next   = reg_wdata[OWN_SW_LSB +: NRES];
      fw_next   = fw_next & ~reg_wdata[OWN_SW_LSB +: NRES];
      lock_next = reg_wdata[OWN_LOCK_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg   <= S_IDLE;
      req_reg     <= '0;
      fw_bits_reg <= '0;
      lock_reg    <= 1'b0;
      il_reg      <= 1'b0;
    end else if (clk_en) begin
      state_reg   <= state_next;
      req_reg     <= req_next;
      fw_bits_reg <= fw_next;
      lock_reg    <= lock_next;
      il_reg      <= il_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      sw_bits_reg <= sw_next;
    end
  end

  assign fw_busy  = state_reg != S_IDLE;
  assign fw_grant = state_reg == S_OWN && (fw_bits_reg & req_reg) == req_reg;

  // ------------------------------------------------------------
  // command engine, token watchdog, management controls
  // ------------------------------------------------------------
  fsr_cmd_state_t cst_reg;
  fsr_cmd_state_t cst_next;
  logic        resp_valid_next;
  fsr_resp_t   resp_next;
  logic        fw_reset_next;
  logic        armed_reg;
  logic        armed_next;
  logic [31:0] rstcnt_reg;
  logic [31:0] rstcnt_next;
  logic        path_reg;
  logic        path_next;
  logic        rx_reg;
  logic        rx_next;
  logic        saved_reg;
  logic        saved_next;
  logic        tok_reg;
  logic        tok_next;
  logic [15:0] cmd_len;
  logic [24:0] cmd_end;
  logic        len_bad;

  // first length byte is the high part
  assign cmd_len   = {cmd.len_msb, cmd.len_lsb};
  assign cmd_end   = {1'b0, cmd.addr} + {9'h000, cmd_len};
  assign len_bad   = cmd_len > MAX_BUF_LEN;
  assign cmd_ready = cst_reg == C_IDLE;

  always_comb begin
    cst_next        = cst_reg;
    resp_valid_next = 1'b0;
    resp_next       = '0;
    fw_reset_next   = 1'b0;
    armed_next      = armed_reg;
    rstcnt_next     = rstcnt_reg;
    path_next       = path_reg;
    rx_next         = rx_reg;
    saved_next      = saved_reg;
    tok_next        = tok_reg;
    tok_start       = 1'b0;
    tok_stop        = 1'b0;
    unique case (cst_reg)
      C_IDLE: begin
        if (cmd_valid) begin
          armed_next      = 1'b0;
          resp_valid_next = 1'b1;
          resp_next.err   = len_bad;
          case (cmd.code)
            CMD_FLASH_RD: resp_next.from_flash = 1'b1;
            CMD_SR_RD: resp_next.err = len_bad || cmd_end > SR_LIMIT;
            CMD_FLASH_WR, CMD_ERASE: begin
              resp_next.err = len_bad || {1'b0, cmd.addr} < SR_LIMIT ||
                              cmd_end > FLASH_WR_END;
            end
            CMD_SR_WR: begin
              resp_next.err = len_bad || {1'b0, cmd.addr} < SR_WR_LO ||
                              cmd_end > SR_LIMIT;
            end
            CMD_MOD_UPD: begin
              resp_next.err = len_bad || cmd_len == 16'h0000;
              armed_next    = !resp_next.err;
            end
            CMD_APPLY: begin
              resp_valid_next = 1'b0;
              if (armed_reg) begin
                fw_reset_next = 1'b1;
                rstcnt_next   = rstcnt_reg + 32'h0000_0001;
              end
            end
            CMD_RX_DIS: begin
              resp_valid_next = 1'b0;
              saved_next      = path_reg;
              cst_next        = C_CLRP;
            end
            CMD_TOKEN_REQ: tok_start = 1'b1;
            CMD_TOKEN_REL: tok_stop  = 1'b1;
            default: resp_next.err = 1'b1;
          endcase
        end
      end
      C_CLRP: begin
        path_next = 1'b0;
        cst_next  = C_CLRR;
      end
      C_CLRR: begin
        rx_next  = 1'b0;
        cst_next = C_REST;
      end
      C_REST: begin
        path_next       = saved_reg;
        resp_valid_next = 1'b1;
        cst_next        = C_IDLE;
      end
    endcase
    // revoke request when token is kept
    if (tmr_exp[T_TOKEN]) begin
      tok_next = 1'b0;
      tok_stop = 1'b1;
    end
    if (tok_wr) begin
      tok_next = reg_wdata[TOKEN_REQ_POS];
    end
    if (mgmt_wr) begin
      path_next = reg_wdata[MGMT_PATH_POS];
      rx_next   = reg_wdata[MGMT_RX_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cst_reg        <= C_IDLE;
      resp_valid     <= 1'b0;
      resp           <= '0;
      fw_reset_pulse <= 1'b0;
      armed_reg      <= 1'b0;
      rstcnt_reg     <= RSTCNT_RST;
      path_reg       <= 1'b0;
      rx_reg         <= 1'b0;
      saved_reg      <= 1'b0;
      tok_reg        <= 1'b0;
    end else if (clk_en) begin
      cst_reg        <= cst_next;
      resp_valid     <= resp_valid_next;
      resp           <= resp_next;
      fw_reset_pulse <= fw_reset_next;
      armed_reg      <= armed_next;
      rstcnt_reg     <= rstcnt_next;
      path_reg       <= path_next;
      rx_reg         <= rx_next;
      saved_reg      <= saved_next;
      tok_reg        <= tok_next;
    end
  end

  assign host_to_mgmt_path  = path_reg;
  assign receive_enable_bit = rx_reg;

  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] own_word;

  // one pair of bits per resource
  always_comb begin
    own_word = '0;
    own_word[OWN_SW_LSB +: NRES] = sw_bits_reg;
    own_word[OWN_FW_LSB +: NRES] = fw_bits_reg;
    own_word[OWN_LOCK_POS]       = lock_reg;
    rd_mux = '0;
    unique case (reg_addr)
      ADDR_SEM:    rd_mux[SEM_IL_POS]    = il_reg;
      ADDR_OWN:    rd_mux                = own_word;
      ADDR_TOKEN:  rd_mux[TOKEN_REQ_POS] = tok_reg;
      ADDR_RSTCNT: rd_mux                = rstcnt_reg;
      ADDR_MGMT:   rd_mux[MGMT_RX_POS:MGMT_PATH_POS] = {rx_reg, path_reg};
      ADDR_FWSTAT: rd_mux[FWSTAT_CMD_LSB+3:0] = {cst_reg, state_reg};
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_interlock_grant: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && sem_rd && !il_reg |=> il_reg && reg_rdata[SEM_IL_POS] == 1'b0)
    else $error("interlock not granted on zero read");

  a_interlock_free: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && sem_wr && !reg_wdata[SEM_IL_POS] |=> !il_reg)
    else $error("interlock not freed by zero write");

  a_pair_exclusive: assert property (@(posedge core_clk) disable iff (reset)
    state_reg == S_OWN |-> (sw_bits_reg & fw_bits_reg) == '0)
    else $error("both bits of a pair set");

  a_lock_seize: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && state_reg == S_POLL && lock_reg && tmr_exp[T_LOCK] && !own_wr
    |=> state_reg == S_CHECK && lock_reg)
    else $error("lock not seized on timeout");

  a_claim_busy: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && state_reg == S_CHECK && !own_wr && (sw_bits_reg & req_reg) != '0 &&
    !tmr_exp[T_FORCE] |=> state_reg == S_WAIT && !lock_reg && (fw_bits_reg & req_reg) == '0)
    else $error("firmware claimed a software-owned resource");

  a_force_own: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && state_reg == S_CHECK && !own_wr && tmr_exp[T_FORCE]
    |=> (sw_bits_reg & req_reg) == '0 && fw_grant)
    else $error("ownership not forced");

  a_release_back: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && state_reg == S_RCLR && !own_wr
    |=> state_reg == S_BACK && !lock_reg && (fw_bits_reg & req_reg) == '0)
    else $error("release left bits or lock set");

  a_token_revoke: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && tmr_exp[T_TOKEN] && !tok_wr |=> !tok_reg)
    else $error("token request not revoked");

  a_apply_gate: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && cmd_ready && cmd_valid && cmd.code == CMD_APPLY
    |=> fw_reset_pulse == $past(armed_reg) && !resp_valid)
    else $error("activation gating wrong");

  a_rx_flow: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && cmd_ready && cmd_valid && cmd.code == CMD_RX_DIS && !mgmt_wr
    ##1 clk_en && !mgmt_wr ##1 clk_en && !mgmt_wr ##1 clk_en && !mgmt_wr
    |=> resp_valid && host_to_mgmt_path == $past(saved_reg) && !receive_enable_bit)
    else $error("receive disable flow wrong");

  a_len_limit: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && cmd_ready && cmd_valid && len_bad && cmd.code != CMD_APPLY &&
    cmd.code != CMD_RX_DIS |=> resp_valid && resp.err)
    else $error("oversize length accepted");

  a_flash_src: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && cmd_ready && cmd_valid && cmd.code == CMD_FLASH_RD |=> resp.from_flash)
    else $error("flash read not from flash");
endmodule

/* fsr_pkg.sv */
// shared constants, types and the countdown timer of the resource semaphore
// assumes a single 10 MHz core clock and one synchronous active-high reset

// ------------------------------------------------------------
// package
// ------------------------------------------------------------
package fsr_pkg;
  localparam int CLK_HZ       = 10_000_000;
  localparam int LOCK_TMO_MS  = 10;
  localparam int RETRY_MS     = 5;
  localparam int FORCE_MS     = 1000;
  localparam int TOKEN_MS     = 1000;
  localparam int LOCK_TMO_CYC = CLK_HZ / 1000 * LOCK_TMO_MS;
  localparam int RETRY_CYC    = CLK_HZ / 1000 * RETRY_MS;
  localparam int FORCE_CYC    = CLK_HZ / 1000 * FORCE_MS;
  localparam int TOKEN_CYC    = CLK_HZ / 1000 * TOKEN_MS;
  localparam int TMR_W        = 24;
  localparam int NUM_TMR      = 4;
  localparam int T_LOCK       = 0;
  localparam int T_RETRY      = 1;
  localparam int T_FORCE      = 2;
  localparam int T_TOKEN      = 3;

  localparam int MAX_RES      = 8;
  localparam int NRES_DEF     = 3;

  localparam logic [3:0] ADDR_SEM    = 4'h0;
  localparam logic [3:0] ADDR_OWN    = 4'h1;
  localparam logic [3:0] ADDR_TOKEN  = 4'h2;
  localparam logic [3:0] ADDR_RSTCNT = 4'h3;
  localparam logic [3:0] ADDR_MGMT   = 4'h4;
  localparam logic [3:0] ADDR_FWSTAT = 4'h5;

  localparam int SEM_IL_POS    = 0;
  localparam int OWN_SW_LSB    = 0;
  localparam int OWN_FW_LSB    = 8;
  localparam int OWN_LOCK_POS  = 31;
  localparam int TOKEN_REQ_POS = 0;
  localparam int MGMT_PATH_POS = 0;
  localparam int MGMT_RX_POS   = 1;
  localparam int FWSTAT_CMD_LSB = 8;

  localparam logic [31:0] RSTCNT_RST = 32'h0000_0000;
  localparam logic [15:0] MAX_BUF_LEN = 16'h0400;
  localparam logic [24:0] SR_LIMIT_DEF     = 25'h000_8000;
  localparam logic [24:0] SR_WR_LO_DEF     = 25'h000_0100;
  localparam logic [24:0] FLASH_WR_END_DEF = 25'h080_0000;

  localparam logic [7:0] CMD_FLASH_RD  = 8'h01;
  localparam logic [7:0] CMD_SR_RD     = 8'h02;
  localparam logic [7:0] CMD_FLASH_WR  = 8'h03;
  localparam logic [7:0] CMD_SR_WR     = 8'h04;
  localparam logic [7:0] CMD_MOD_UPD   = 8'h05;
  localparam logic [7:0] CMD_APPLY     = 8'h06;
  localparam logic [7:0] CMD_ERASE     = 8'h07;
  localparam logic [7:0] CMD_RX_DIS    = 8'h08;
  localparam logic [7:0] CMD_TOKEN_REQ = 8'h09;
  localparam logic [7:0] CMD_TOKEN_REL = 8'h0a;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  len_msb;
    logic [7:0]  len_lsb;
    logic [23:0] addr;
  } fsr_cmd_t;

  typedef struct packed {
    logic err;
    logic from_flash;
  } fsr_resp_t;

  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_POLL  = 8'b0000_0010,
    S_CHECK = 8'b0000_0100,
    S_WAIT  = 8'b0000_1000,
    S_OWN   = 8'b0001_0000,
    S_RPOLL = 8'b0010_0000,
    S_RCLR  = 8'b0100_0000,
    S_BACK  = 8'b1000_0000
  } fsr_sem_state_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_CLRP = 4'b0010,
    C_CLRR = 4'b0100,
    C_REST = 4'b1000
  } fsr_cmd_state_t;
endpackage

// ------------------------------------------------------------
// countdown timer
// ------------------------------------------------------------
module fsr_timer import fsr_pkg::*; #(
  parameter int W = TMR_W
) (
  // clock and control
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // timer control
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] load,
  // status
  output logic              expired
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         run_reg;
  logic         run_next;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (stop) begin
      run_next = 1'b0;
    end else if (start) begin
      cnt_next = load;
      run_next = 1'b1;
    end else if (run_reg && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  // level until restarted or stopped
  assign expired = run_reg && cnt_reg == '0;
endmodule

/* fsr_host_model.sv */
// register-bus host standing in for the driver software
// assumes the device answers a read in the cycle after the strobe
module fsr_host_model import fsr_pkg::*; (
  // clock
  input  wire logic        core_clk,
  // register port
  output logic [3:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic take(input logic [31:0] m, output logic ok);
    logic [31:0] v;
    rd(ADDR_SEM, v);
    rd(ADDR_OWN, v);
    ok = (v[OWN_LOCK_POS] === 1'b0) && ((v[10:8] & m[2:0]) === 3'h0);
    wr(ADDR_OWN, ok ? m : 32'h0);
    wr(ADDR_SEM, 32'h0);
  endtask
endmodule

/* tb_top.sv */
// bench of the resource semaphore and firmware command engine
// assumes small timer parameters; host model drives registers
module tb_top import fsr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, fw_req, fw_rel, cmd_valid, got;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, fw_grant, fw_busy, cmd_ready, resp_valid;
  logic fw_reset_pulse, host_to_mgmt_path, receive_enable_bit;
  logic [2:0] fw_req_mask;
  logic [15:0] l;
  logic [23:0] a;
  logic [7:0] c;
  logic [7:0] codes [5] = '{CMD_FLASH_RD, CMD_SR_RD, CMD_FLASH_WR, CMD_SR_WR, CMD_ERASE};
  fsr_cmd_t cmd;
  fsr_resp_t resp, rsp;
  int num_errors, n_compared;
  int n_pulse = 0;
  fsr_host_model host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  fsr_semaphore_top #(.LOCK_TMO_CYC_P(8), .RETRY_CYC_P(4), .FORCE_CYC_P(40),
    .TOKEN_CYC_P(40)) dut (.core_clk, .reset, .clk_en(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .fw_req, .fw_req_mask, .fw_rel, .fw_grant, .fw_busy,
    .cmd_valid, .cmd, .cmd_ready, .resp_valid, .resp, .fw_reset_pulse,
    .host_to_mgmt_path, .receive_enable_bit);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fw_reset_pulse === 1'b1) n_pulse++;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for grant or idle
  task automatic fwait(input bit g);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge core_clk);
      #1;
      if (g ? fw_grant === 1'b1 : fw_busy === 1'b0) break;
    end
    if (i == 300) begin
      chk("fw_wait", 32'h1, 32'h0);
      tally_and_finish;
    end
  endtask
  task automatic fw(input logic [2:0] m, input bit rel);
    @(posedge core_clk);
    fw_req      <= !rel;
    fw_rel      <= rel;
    fw_req_mask <= m;
    @(posedge core_clk);
    fw_req <= 1'b0;
    fw_rel <= 1'b0;
    fwait(!rel);
  endtask
  task automatic send(input logic [7:0] c, input logic [15:0] l, input logic [23:0] a);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd       <= '{c, l[15:8], l[7:0], a};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    got = 1'b0;
    for (int i = 0; i < 6 && !got; i++) begin
      #1 got = (resp_valid === 1'b1);
      rsp = resp;
      if (!got) @(posedge core_clk);
    end
  endtask
  function automatic logic exp_err(input logic [7:0] c, input logic [15:0] l,
                                   input logic [23:0] a);
    logic [24:0] e;
    e = a + l;
    if (l > MAX_BUF_LEN) return 1'b1;
    case (c)
      CMD_SR_RD: return e > SR_LIMIT_DEF;
      CMD_SR_WR: return a < SR_WR_LO_DEF || e > SR_LIMIT_DEF;
      CMD_FLASH_WR, CMD_ERASE: return a < SR_LIMIT_DEF || e > FLASH_WR_END_DEF;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    reset = 1'b1;
    {fw_req, fw_rel, fw_req_mask, cmd_valid, cmd} = '0;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(32'hd005));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    host.wr(ADDR_OWN, 32'h0);
    for (int k = 0; k < 3; k++) begin
      host.rd(ADDR_SEM, v);
      chk("sem", 32'(k != 0), v);
    end
    host.wr(ADDR_SEM, 32'h0);
    host.rd(ADDR_SEM, v);
    chk("sem_clr", 32'h0, v);
    host.wr(ADDR_SEM, 32'h0);
    host.rd(4'hf, v);
    chk("unmapped", 32'h0, v);
    fw(3'h1, 0);
    host.rd(ADDR_OWN, v);
    chk("own", 32'h100, v);
    fw(3'h1, 1);
    host.rd(ADDR_OWN, v);
    chk("own", 32'h0, v);
    host.take(32'h2, got);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    host.rd(ADDR_OWN, v);
    chk("own", 32'h2, v);
    fw(3'h2, 0);
    host.rd(ADDR_OWN, v);
    chk("own", 32'h200, v);
    fw(3'h2, 1);
    host.wr(ADDR_OWN, 32'h8000_0000);
    fw(3'h1, 0);
    host.rd(ADDR_OWN, v);
    chk("own", 32'h100, v);
    host.wr(ADDR_OWN, 32'h1);
    host.rd(ADDR_OWN, v);
    chk("own", 32'h1, v);
    fw(3'h1, 1);
    host.take(32'h0, got);
    host.rd(ADDR_OWN, v);
    chk("own", 32'h0, v);
    for (int i = 0; i < 40; i++) begin
      c = codes[i % 5];
      l = i < 10 ? 16'h0400 : 16'($urandom_range(16'h0480));
      a = i < 10 ? 24'h7c00 + 24'(i / 5) : 24'($urandom) >> $urandom_range(16);
      send(c, l, a);
      chk("resp", 32'h1, 32'(got));
      chk("err", 32'(exp_err(c, l, a)), 32'(rsp.err));
      if (c == CMD_FLASH_RD && !exp_err(c, l, a)) chk("flash", 32'h1, 32'(rsp.from_flash));
    end
    host.wr(ADDR_MGMT, 32'h3);
    send(CMD_RX_DIS, 16'h0, 24'h0);
    chk("rx_resp", 32'h1, 32'(got));
    host.rd(ADDR_MGMT, v);
    chk("mgmt", 32'h1, v);
    chk("path", 32'h1, 32'(host_to_mgmt_path));
    chk("receive_enable_bit", 32'h0, 32'(receive_enable_bit));
    host.rd(ADDR_RSTCNT, v);
    chk("rstcnt0", 32'h0, v);
    for (int k = 0; k < 3; k++) begin
      send(CMD_MOD_UPD, 16'(k == 2), 24'h0);
      send(CMD_APPLY, 16'h0, 24'h0);
      chk("apply_resp", 32'h0, 32'(got));
    end
    chk("pulses", 32'h1, 32'(n_pulse));
    host.rd(ADDR_RSTCNT, v);
    chk("rstcnt", 32'h1, v);
    for (int k = 0; k < 2; k++) begin
      host.wr(ADDR_TOKEN, 32'h1);
      send(CMD_TOKEN_REQ, 16'h0, 24'h0);
      if (k == 1) send(CMD_TOKEN_REL, 16'h0, 24'h0);
      repeat (50) @(posedge core_clk);
      host.rd(ADDR_TOKEN, v);
      chk("token", 32'(k), v);
    end
    tally_and_finish;
  end
endmodule
